// File: inc/ops_cfg.svh
// Constants of the OLED panel power sequencer
// Overview of operation
// - Clear stays low until low supply risen
// - First setting writes six startup bytes
// - Core save off, then interface >200us later
// - Wait >4 sync periods, write 0x3F
// - Wait >1 sync period, write 0x46 pair
// - Wait >1 sync period, zero four registers
// - High supply on within 3 syncs
// - Power down: core, interface save on
// - Clear low after save, then supplies off
// - Power-save communication enable held low
// - Vertical sync is active low
// - Video reset high at least 3 clocks
// - Serial clock at most 2.5 MHz
// - Video link: one clock, twelve data pairs
// - Video 1920x1080, 60 Hz, 8-bit colour
`ifndef OPS_CFG_SVH
`define OPS_CFG_SVH
// Clock and timing
`define OPS_CLK_KHZ        20000
`define OPS_SCK_KHZ        800
`define OPS_SCK_HALF_CYC   ((`OPS_CLK_KHZ + 2 * `OPS_SCK_KHZ - 1) / (2 * `OPS_SCK_KHZ))
`define OPS_PS_GAP_US      200
`define OPS_PS_GAP_CYC     ((`OPS_PS_GAP_US * `OPS_CLK_KHZ) / 1000)
`define OPS_VD_GAP_LONG    5
`define OPS_VD_GAP_SHORT   2
`define OPS_VD_GAP_DOWN    1
// Panel register addresses
`define OPS_PA_MAIN        8'h00
`define OPS_PA_IFACE       8'h01
`define OPS_PA_HSHIFT      8'h02
`define OPS_PA_START4      8'h04
`define OPS_PA_FRMODE      8'h6d
`define OPS_PA_START6F     8'h6f
`define OPS_PA_START71     8'h71
`define OPS_PA_START72     8'h72
// Sequence step indices
`define OPS_STEP_CORE_OFF  5'd6
`define OPS_STEP_IF_OFF    5'd7
`define OPS_STEP_SET4      5'd8
`define OPS_STEP_SET5A     5'd9
`define OPS_STEP_SET6A     5'd11
`define OPS_STEP_UP_LAST   5'd14
`define OPS_STEP_DOWN      5'd15
`define OPS_STEP_DOWN_LAST 5'd16
// Own register map
`define OPS_REG_CTRL       4'h0
`define OPS_REG_STATUS     4'h4
`define OPS_CTRL_UP_BIT    0
`define OPS_CTRL_DOWN_BIT  1
// Video format figures
`define OPS_VID_H_ACTIVE   1920
`define OPS_VID_V_ACTIVE   1080
`define OPS_VID_FRAME_HZ   60
`define OPS_VID_DATA_PAIRS 12
`endif

// File: inc/ops_pkg.sv
// Types of the OLED panel power sequencer
`default_nettype none
package ops_pkg;
    typedef enum logic [2:0] {
        ops_st_off   = 3'b000,
        ops_st_rise  = 3'b001,
        ops_st_send  = 3'b010,
        ops_st_gap   = 3'b011,
        ops_st_on    = 3'b100,
        ops_st_clear = 3'b101,
        ops_st_cut   = 3'b110
    } ops_state_type;
    typedef enum logic [2:0] {
        ops_wait_none  = 3'b000,
        ops_wait_ps    = 3'b001,
        ops_wait_long  = 3'b010,
        ops_wait_short = 3'b011,
        ops_wait_down  = 3'b100
    } ops_wait_type;
endpackage : ops_pkg
`default_nettype wire

// File: hw/ops_sequencer.sv
// Host-side power sequencer for the OLED panel with AXI4-Lite control
`include "ops_cfg.svh"
`default_nettype none
module ops_sequencer #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Panel serial setting port
    output logic                       serial_select_n,
    output logic                       serial_setting_clock,
    output logic                       serial_data_out,
    // Panel control pins
    output logic                       panel_clear_n,
    output logic                       psave_comm_enable_n,
    input  wire logic                  vertical_sync_n,
    // Supply control
    output logic                       low_voltage_supply,
    output logic                       high_voltage_supply,
    input  wire logic                  low_supply_good
);
    import ops_pkg::*;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    localparam logic [12:0] HALF_CYC = 13'(`OPS_SCK_HALF_CYC);
    localparam logic [12:0] PS_CYC   = 13'(`OPS_PS_GAP_CYC + 1);

    ops_state_type state;
    ops_wait_type  gap_kind;
    logic [4:0]    step;
    logic          vd_meta, vd_q, vd_prev, good_meta, good_q;
    logic          vd_fall;
    logic          ser_active, ser_hold, ser_tick, frame_done;
    logic [12:0]   ser_cnt;
    logic [15:0]   ser_shift;
    logic [3:0]    ser_bit;
    logic [12:0]   gap_cyc;
    logic [2:0]    gap_vd;
    logic          gap_done;
    logic          up_req, down_req, ctrl_wr;
    logic          aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;

    // Address and data of each serial write, in sequence order
    function automatic logic [15:0] ops_step_word(input logic [4:0] s);
        case (s)
            5'd0:  ops_step_word = {`OPS_PA_HSHIFT, 8'h40};
            5'd1:  ops_step_word = {`OPS_PA_START4, 8'h5f};
            5'd2:  ops_step_word = {`OPS_PA_FRMODE, 8'h04};
            5'd3:  ops_step_word = {`OPS_PA_START6F, 8'h03};
            5'd4:  ops_step_word = {`OPS_PA_START71, 8'h4e};
            5'd5:  ops_step_word = {`OPS_PA_START72, 8'h4e};
            5'd6:  ops_step_word = {`OPS_PA_MAIN, 8'h0f};
            5'd7:  ops_step_word = {`OPS_PA_IFACE, 8'h01};
            5'd8:  ops_step_word = {`OPS_PA_START4, 8'h3f};
            5'd9:  ops_step_word = {`OPS_PA_START71, 8'h46};
            5'd10: ops_step_word = {`OPS_PA_START72, 8'h46};
            5'd11: ops_step_word = {`OPS_PA_FRMODE, 8'h00};
            5'd12: ops_step_word = {`OPS_PA_START6F, 8'h00};
            5'd13: ops_step_word = {`OPS_PA_START71, 8'h00};
            5'd14: ops_step_word = {`OPS_PA_START72, 8'h00};
            5'd15: ops_step_word = {`OPS_PA_MAIN, 8'h0e};
            5'd16: ops_step_word = {`OPS_PA_IFACE, 8'h00};
            default: ops_step_word = 16'h0000;
        endcase
    endfunction : ops_step_word

    // Wait that must follow each write before the next one
    function automatic ops_wait_type ops_step_wait(input logic [4:0] s);
        case (s)
            5'd6:  ops_step_wait = ops_wait_ps;
            5'd7:  ops_step_wait = ops_wait_long;
            5'd8:  ops_step_wait = ops_wait_short;
            5'd10: ops_step_wait = ops_wait_short;
            5'd16: ops_step_wait = ops_wait_down;
            default: ops_step_wait = ops_wait_none;
        endcase
    endfunction : ops_step_wait

    // Pin synchronisers; the first (meta) stage is never looked at
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vd_meta   <= 1'b1;
            vd_q      <= 1'b1;
            vd_prev   <= 1'b1;
            good_meta <= 1'b0;
            good_q    <= 1'b0;
        end else begin
            vd_meta   <= vertical_sync_n;
            vd_q      <= vd_meta;
            vd_prev   <= vd_q;
            good_meta <= low_supply_good;
            good_q    <= good_meta;
        end
    end

    // Sync pulse starts on the falling edge
    assign vd_fall = vd_prev && !vd_q;

    // Fixed level, the only one the panel accepts
    assign psave_comm_enable_n = 1'b0;

    // Sequencer state and step index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ops_st_off;
            step  <= 5'd0;
        end else begin
            unique case (state)
                ops_st_off:   if (up_req) state <= ops_st_rise;
                ops_st_rise: begin
                    if (good_q) begin
                        state <= ops_st_send;
                        step  <= 5'd0;
                    end
                end
                ops_st_send:  if (frame_done) state <= ops_st_gap;
                ops_st_gap: begin
                    if (gap_done) begin
                        if (step == `OPS_STEP_UP_LAST) state <= ops_st_on;
                        else if (step == `OPS_STEP_DOWN_LAST) state <= ops_st_clear;
                        else begin
                            state <= ops_st_send;
                            step  <= step + 5'd1;
                        end
                    end
                end
                ops_st_on: begin
                    if (down_req) begin
                        state <= ops_st_send;
                        step  <= `OPS_STEP_DOWN;
                    end
                end
                ops_st_clear: state <= ops_st_cut;
                ops_st_cut:   state <= ops_st_off;
                default:      state <= ops_st_off;
            endcase
        end
    end

    // Serial frame: 8 address bits then 8 data bits, MSB first, sampled on rise
    assign ser_tick   = ser_active && (ser_cnt == HALF_CYC - 13'd1);
    assign frame_done = ser_tick && ser_hold;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_active           <= 1'b0;
            ser_hold             <= 1'b0;
            ser_cnt              <= 13'd0;
            ser_shift            <= 16'h0000;
            ser_bit              <= 4'd0;
            serial_select_n      <= 1'b1;
            serial_setting_clock <= 1'b0;
            serial_data_out      <= 1'b0;
        end else if (!ser_active) begin
            // Select low leads the first rise by half a period of setup
            if (state == ops_st_send) begin
                ser_active      <= 1'b1;
                ser_hold        <= 1'b0;
                ser_cnt         <= 13'd0;
                ser_shift       <= ops_step_word(step);
                ser_bit         <= 4'd15;
                serial_select_n <= 1'b0;
                serial_data_out <= ops_step_word(step)[15];
            end
        end else if (!ser_tick) begin
            ser_cnt <= ser_cnt + 13'd1;
        end else begin
            ser_cnt <= 13'd0;
            if (ser_hold) begin
                serial_select_n <= 1'b1;
                ser_active      <= 1'b0;
            end else if (!serial_setting_clock) begin
                serial_setting_clock <= 1'b1;
            end else begin
                serial_setting_clock <= 1'b0;
                if (ser_bit == 4'd0) begin
                    ser_hold <= 1'b1;
                end else begin
                    ser_bit         <= ser_bit - 4'd1;
                    serial_data_out <= ser_shift[ser_bit-4'd1];
                end
            end
        end
    end

    // Gap timer starts when select goes high at the end of a frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_kind <= ops_wait_none;
            gap_cyc  <= 13'd0;
            gap_vd   <= 3'd0;
        end else if (frame_done) begin
            gap_kind <= ops_step_wait(step);
            gap_cyc  <= 13'd0;
            gap_vd   <= 3'd0;
        end else if (state == ops_st_gap) begin
            if (gap_cyc != 13'h1fff) gap_cyc <= gap_cyc + 13'd1;
            // Falls seen in the first two gap cycles predate select rising
            if (vd_fall && gap_cyc >= 13'd2 && gap_vd != 3'd7) gap_vd <= gap_vd + 3'd1;
        end
    end

    // Every gap also keeps select high for at least half a clock period
    always_comb begin
        gap_done = 1'b0;
        if (state == ops_st_gap && gap_cyc >= HALF_CYC) begin
            unique case (gap_kind)
                ops_wait_none:  gap_done = 1'b1;
                ops_wait_ps:    gap_done = gap_cyc >= PS_CYC;
                ops_wait_long:  gap_done = gap_vd >= 3'(`OPS_VD_GAP_LONG);
                ops_wait_short: gap_done = gap_vd >= 3'(`OPS_VD_GAP_SHORT);
                ops_wait_down:  gap_done = gap_vd >= 3'(`OPS_VD_GAP_DOWN);
                default:        gap_done = 1'b0;
            endcase
        end
    end

    // Supplies and clear pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_voltage_supply  <= 1'b0;
            high_voltage_supply <= 1'b0;
            panel_clear_n       <= 1'b0;
        end else begin
            if (state == ops_st_off && up_req) low_voltage_supply <= 1'b1;
            if (state == ops_st_rise && good_q) panel_clear_n <= 1'b1;
            // High supply switched at once, well inside three sync periods
            if (frame_done && step == `OPS_STEP_IF_OFF) high_voltage_supply <= 1'b1;
            if (state == ops_st_clear) panel_clear_n <= 1'b0;
            if (state == ops_st_cut) begin
                low_voltage_supply  <= 1'b0;
                high_voltage_supply <= 1'b0;
            end
        end
    end

    // Write channel: address and data taken in any order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= '0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == ADDR_W'(`OPS_REG_CTRL)) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
        end
    end

    // Control writes are one-shot requests; a wrong-state request is dropped
    assign ctrl_wr  = aw_held && w_held && w_strb[0] && (aw_addr == ADDR_W'(`OPS_REG_CTRL));
    assign up_req   = ctrl_wr && w_data[`OPS_CTRL_UP_BIT];
    assign down_req = ctrl_wr && w_data[`OPS_CTRL_DOWN_BIT];

    // Read channel: one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            if (s_axi_araddr == ADDR_W'(`OPS_REG_STATUS)) begin
                s_axi_rdata <= {11'h000, step, 5'h00, state, 3'h0, panel_clear_n,
                                high_voltage_supply, low_voltage_supply,
                                (state == ops_st_on),
                                (state != ops_st_off && state != ops_st_on)};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                if (s_axi_araddr != ADDR_W'(`OPS_REG_CTRL)) s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
    end

    // Helper counters of select-high time, for the checks only
    logic [12:0] chk_cyc;
    logic [2:0]  chk_vd;
    always_ff @(posedge aclk) begin
        if (!aresetn || !serial_select_n) begin
            chk_cyc <= 13'd0;
            chk_vd  <= 3'd0;
        end else begin
            if (chk_cyc != 13'h1fff) chk_cyc <= chk_cyc + 13'd1;
            if (vd_fall && chk_cyc >= 13'd2 && chk_vd != 3'd7) chk_vd <= chk_vd + 3'd1;
        end
    end

    sequence s_frame_start(logic [4:0] n);
        $fell(serial_select_n) && step == n;
    endsequence

    property p_clear_after_rise;
        $rose(panel_clear_n) |-> low_voltage_supply && good_q;
    endproperty
    a_clear_after_rise: assert property (p_clear_after_rise)
        else $error("clear released too early");
    property p_first_write;
        s_frame_start(5'd0) |-> ser_shift == 16'h0240 && serial_data_out == 1'b0;
    endproperty
    a_first_write: assert property (p_first_write)
        else $error("bad first write");
    property p_ps_gap;
        s_frame_start(`OPS_STEP_IF_OFF) |-> $past(chk_cyc) > 13'd4000;
    endproperty
    a_ps_gap: assert property (p_ps_gap)
        else $error("interface write too soon");
    property p_long_gap;
        s_frame_start(`OPS_STEP_SET4) |-> $past(chk_vd) >= 3'd5;
    endproperty
    a_long_gap: assert property (p_long_gap)
        else $error("write four too soon");
    property p_short_gap;
        (s_frame_start(`OPS_STEP_SET5A) or s_frame_start(`OPS_STEP_SET6A))
            |-> $past(chk_vd) >= 3'd2;
    endproperty
    a_short_gap: assert property (p_short_gap)
        else $error("sync gap too short");
    property p_hv_on;
        $rose(high_voltage_supply) |-> $past(frame_done) && $past(step) == `OPS_STEP_IF_OFF;
    endproperty
    a_hv_on: assert property (p_hv_on)
        else $error("high supply mistimed");
    property p_supply_off;
        $fell(panel_clear_n) |=> !low_voltage_supply && !high_voltage_supply && !panel_clear_n;
    endproperty
    a_supply_off: assert property (p_supply_off)
        else $error("supplies not removed after clear");
    property p_clear_low_after_save;
        $fell(panel_clear_n) |-> $past(step) == `OPS_STEP_DOWN_LAST && serial_select_n;
    endproperty
    a_clear_low_after_save: assert property (p_clear_low_after_save)
        else $error("clear low too early");
    property p_psave_low;
        !psave_comm_enable_n;
    endproperty
    a_psave_low: assert property (p_psave_low)
        else $error("power save enable not low");
    property p_sck_high;
        $rose(serial_setting_clock) |-> serial_setting_clock [*8] ##5 serial_setting_clock;
    endproperty
    a_sck_high: assert property (p_sck_high)
        else $error("clock high too short");
    property p_select_setup;
        $fell(serial_select_n) |-> !serial_setting_clock [*8];
    endproperty
    a_select_setup: assert property (p_select_setup)
        else $error("clock too soon after select");

endmodule : ops_sequencer
`default_nettype wire

// File: sim/ops_panel_model.sv
// Behavioural panel: serial register file, frame log and sync count
`default_nettype none
module ops_panel_model (
    // Serial setting port
    input  wire logic serial_select_n,
    input  wire logic serial_setting_clock,
    input  wire logic serial_data_in,
    // Clear and sync pins
    input  wire logic panel_clear_n,
    input  wire logic vertical_sync_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  regs [0:255];
    logic [15:0] shreg;
    logic [15:0] log_word [0:31];
    logic        log_ps [0:31];
    int          n_log = 0;
    int          n_bits = 0;
    int          n_vd = 0;
    int          bad_frames = 0;
    int          start_vd [0:31];
    int          end_vd [0:31];
    realtime     start_t [0:31];
    realtime     end_t [0:31];
    realtime     last_sck = 0;
    realtime     min_half = 1.0e9;
    // Clear puts the panel in power save
    always @(negedge panel_clear_n) begin
        regs[8'h00] = 8'h0e;
        regs[8'h01] = 8'h00;
    end
    // Count sync falls, active low
    always @(negedge vertical_sync_n) n_vd++;
    // Shortest serial clock half period
    always @(serial_setting_clock) begin
        if (last_sck > 0 && $realtime - last_sck < min_half) min_half = $realtime - last_sck;
        last_sck = $realtime;
    end
    // Bits taken on the rising clock, MSB first
    always @(posedge serial_setting_clock) if (!serial_select_n) begin
        shreg = {shreg[14:0], serial_data_in};
        n_bits++;
    end
    // Frame opens
    always @(negedge serial_select_n) begin
        n_bits = 0;
        start_vd[n_log] = n_vd;
        start_t[n_log] = $realtime;
    end
    // Whole frames only reach the registers; short ones are counted as faults
    always @(posedge serial_select_n) begin
        if (n_bits == 16) begin
            regs[shreg[15:8]] = shreg[7:0];
            log_word[n_log] = shreg;
            log_ps[n_log] = !(regs[8'h00][0] && regs[8'h01][0]);
            end_vd[n_log] = n_vd;
            end_t[n_log] = $realtime;
            n_log++;
        end else if (n_bits != 0) bad_frames++;
    end
endmodule : ops_panel_model
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the panel power sequencer
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ops_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, vertical_sync_n = 1'b1;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        serial_select_n, serial_setting_clock, serial_data_out, panel_clear_n;
    logic        psave_comm_enable_n, low_voltage_supply, high_voltage_supply;
    logic [7:0]  supply_dly = 8'h0;
    wire logic   low_supply_good = supply_dly[7];
    logic        bad_clear = 1'b0, bad_psc = 1'b0;
    int          n_mismatch = 0, compares = 0, cycles = 0, hv_vd = 0;
    realtime     t_clr, t_lv_off, t_hv_off;
    localparam logic [15:0] EXP_SEQ [0:14] = '{16'h0240, 16'h045f, 16'h6d04, 16'h6f03,
        16'h714e, 16'h724e, 16'h000f, 16'h0101, 16'h043f, 16'h7146, 16'h7246, 16'h6d00,
        16'h6f00, 16'h7100, 16'h7200};
    ops_sequencer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_select_n, .serial_setting_clock,
        .serial_data_out, .panel_clear_n, .psave_comm_enable_n, .vertical_sync_n,
        .low_voltage_supply, .high_voltage_supply, .low_supply_good);
    ops_panel_model i_panel (.serial_select_n, .serial_setting_clock,
        .serial_data_in(serial_data_out), .panel_clear_n, .vertical_sync_n);
    // Clock, and a free-running sync with unrelated phase
    always #25 aclk = ~aclk;
    initial begin
        #13;
        forever begin
            vertical_sync_n = 1'b0;
            #100 vertical_sync_n = 1'b1;
            #300;
        end
    end
    // Supply takes eight cycles to rise or fall
    always @(posedge aclk) supply_dly <= {supply_dly[6:0], low_voltage_supply};
    // Sticky pin flags and the hang limit
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (panel_clear_n === 1'b1 && low_supply_good !== 1'b1) bad_clear <= 1'b1;
        if (psave_comm_enable_n !== 1'b0) bad_psc <= 1'b1;
        if (cycles == 60000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // Moments of supply and clear edges
    always @(posedge high_voltage_supply) hv_vd = i_panel.n_vd;
    always @(negedge panel_clear_n) t_clr = $realtime;
    always @(negedge low_voltage_supply) t_lv_off = $realtime;
    always @(negedge high_voltage_supply) t_hv_off = $realtime;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check
    // Answers are taken at the edge they stand for, read just before it
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t;
        r_t = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end
    endtask : axi_read
    task automatic wait_status(input logic [31:0] mask, input logic [31:0] val);
        logic [31:0] d;
        logic [1:0]  r;
        d = ~val;
        while ((d & mask) !== val) axi_read(4'h4, d, r);
    endtask : wait_status
    task automatic sc_idle();
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(4'h0, 32'h2, r);
        check(32'(r), 32'h0, "ctrl write resp");
        axi_write(4'h4, 32'h1, r);
        check(32'(r), 32'h2, "status write resp");
        axi_write(4'hc, 32'h1, r);
        check(32'(r), 32'h2, "unmapped write resp");
        axi_read(4'h8, d, r);
        check(d + 32'(r), 32'h2, "unmapped read");
        axi_read(4'h4, d, r);
        check(d & 32'h71f, 32'h0, "idle status");
        check(32'({low_voltage_supply, panel_clear_n, serial_select_n}), 32'h1, "idle pins");
    endtask : sc_idle
    task automatic sc_power_up();
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(4'h0, 32'h1, r);
        wait_status(32'h2, 32'h2);
        for (int k = 0; k < 15; k++) check(32'(i_panel.log_word[k]), 32'(EXP_SEQ[k]), "word");
        for (int k = 0; k < 15; k++) check(32'(i_panel.log_ps[k]), 32'(k < 7), "save state");
        check(32'(i_panel.start_t[7] - i_panel.end_t[6] > 200000.0), 32'h1, "core gap");
        check(32'(i_panel.start_vd[8] - i_panel.end_vd[7] > 4), 32'h1, "gap four");
        check(32'(i_panel.start_vd[9] - i_panel.end_vd[8] > 1), 32'h1, "gap one");
        check(32'(i_panel.start_vd[11] - i_panel.end_vd[10] > 1), 32'h1, "gap zero");
        check(32'(hv_vd - i_panel.end_vd[7] inside {[0:3]}), 32'h1, "high supply late");
        check(32'(i_panel.min_half >= 200.0), 32'h1, "serial clock fast");
        axi_write(4'h0, 32'h1, r);
        axi_read(4'h4, d, r);
        check(d & 32'h71f, (32'(ops_st_on) << 8) | 32'h1e, "on status");
        check(32'(serial_select_n), 32'h1, "up while on");
    endtask : sc_power_up
    task automatic sc_power_down();
        logic [1:0] r;
        axi_write(4'h0, 32'h2, r);
        wait_status(32'h71f, 32'h0);
        check(32'(i_panel.log_word[15]), 32'h000e, "core save on");
        check(32'(i_panel.log_word[16]), 32'h0100, "iface save on");
        check(32'(i_panel.log_ps[16]), 32'h1, "save at end");
        check(32'(t_clr > i_panel.end_t[16]), 32'h1, "clear early");
        check(32'(t_lv_off >= t_clr && t_hv_off >= t_clr), 32'h1, "supplies early");
        check(32'(i_panel.n_log + i_panel.bad_frames), 32'd17, "frame count");
        check(32'(bad_clear), 32'h0, "clear before supply");
        check(32'(bad_psc), 32'h0, "comm enable level");
    endtask : sc_power_down
    task automatic tally_and_finish();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // Reset two cycles, then the scenarios
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        sc_idle();
        sc_power_up();
        sc_power_down();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
